// ===== src/spm_top.sv
`timescale 1ns/1ns
module spm_top import spm_pkg::*; #(
  parameter logic [TMO_W-1:0] TIMEOUT_CYCLES = SENSE_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // weld sequence side
  input wire logic line_tick_i,
  input wire logic start_i,
  input wire logic [VAL_W-1:0] sensor_code_i,
  input wire logic [IDX_W-1:0] nv_index_i,
  output logic [VALVE_N-1:0] valve_o,
  output logic squeezing_o,
  output logic valve_not_ready_flag_o,
  output logic step_done_o,
  output logic seq_off_o,
  output logic irq_o,
  output logic nv_store_o,
  output logic [IDX_W-1:0] nv_index_o
);
  spm_link_if lk ();

  spm_sched_mem u_mem (
    .clock_i(clock_i),
    .lk(lk)
  );

  spm_conv u_conv (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .lk(lk)
  );

  // bus and register state
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [DATA_W-1:0] prdata_reg, prdata_next;
  logic [1:0] unit_reg, unit_next;
  logic [VAL_W-1:0] dia_reg, dia_next;
  logic [IDX_W-1:0] sel_reg, sel_next;
  logic [IDX_W-1:0] edit_reg, edit_next;
  logic [STATUS_W-1:0] status_reg, status_next;
  logic [STATUS_W-1:0] irq_en_reg, irq_en_next;
  logic irq_reg, irq_next;
  logic nv_loaded_reg, nv_loaded_next;
  logic nv_store_reg, nv_store_next;
  // pin synchroniser
  logic [2:0] sync_reg, sync_next;
  logic lvl_reg, lvl_next;
  // sequencer state
  spm_state_e state_reg, state_next;
  logic [IDX_W-1:0] run_reg, run_next;
  logic [IDX_W-1:0] cnt_reg, cnt_next;
  logic [TMO_W-1:0] wait_reg, wait_next;
  logic [VALVE_N-1:0] valve_reg, valve_next;
  logic sqz_reg, sqz_next;
  logic nrdy_reg, nrdy_next;
  logic done_reg, done_next;
  logic off_reg, off_next;
  // decode and events
  logic access, wr_fire, hit, start_cmd, abort_cmd;
  logic [DATA_W-1:0] rd_val;
  logic [STATUS_W-1:0] ev;
  logic [STATUS_W-1:0] clr_mask;
  logic [IDX_W-1:0] sq_len;
  logic [IDX_W-1:0] nxt_idx;
  logic mon_en, pre_en, chain_en, trig_met;
  spm_sense_e sense;
  logic [VAL_W-1:0] trig;

  // start pin: three stages, a level counts once stages two and three agree
  always_comb begin
    sync_next = {sync_reg[1:0], start_i};
    lvl_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : lvl_reg;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sync_reg <= '0;
      lvl_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      lvl_reg <= lvl_next;
    end
  end

  // address decode and read mux
  always_comb begin
    hit = 1'b1;
    rd_val = '0;
    case (paddr_i)
      REG_CFG: begin
        rd_val[CFG_UNIT_LSB +: 2] = unit_reg;
        rd_val[CFG_DIA_LSB +: VAL_W] = dia_reg;
      end
      REG_SEL: rd_val[IDX_W-1:0] = sel_reg;
      REG_EDIT: rd_val[IDX_W-1:0] = edit_reg;
      REG_SEQ: rd_val = lk.ed_q[WORD_SEQ];
      REG_LIM: rd_val = lk.ed_q[WORD_LIM];
      REG_TRIG: rd_val = lk.ed_q[WORD_TRIG];
      REG_CTRL: rd_val = '0;
      REG_STATUS: rd_val[STATUS_W-1:0] = status_reg;
      REG_IRQ_EN: rd_val[STATUS_W-1:0] = irq_en_reg;
      REG_IRQ_CLR: rd_val = '0;
      REG_STATE: begin
        rd_val[STV_STATE_LSB +: 3] = state_reg;
        rd_val[STV_RUN_LSB +: IDX_W] = run_reg;
        rd_val[STV_CNT_LSB +: IDX_W] = cnt_reg;
      end
      REG_MEAS: rd_val[VAL_W-1:0] = lk.meas;
      default: hit = 1'b0;
    endcase
  end

  // apb answer, configuration, schedule writes, status
  always_comb begin
    access = psel_i & penable_i;
    wr_fire = access & pwrite_i & pready_reg & hit;
    pready_next = access & ~pready_reg;
    pslverr_next = access & ~pready_reg & ~hit;
    prdata_next = (access & ~pready_reg & ~pwrite_i) ? rd_val : '0;
    unit_next = unit_reg;
    dia_next = dia_reg;
    sel_next = sel_reg;
    edit_next = edit_reg;
    irq_en_next = irq_en_reg;
    nv_loaded_next = 1'b1;
    nv_store_next = 1'b0;
    clr_mask = '0;
    start_cmd = lvl_next & ~lvl_reg;
    abort_cmd = 1'b0;
    lk.wr_en = 1'b0;
    lk.wr_word = WORD_SEQ;
    lk.wr_addr = edit_reg;
    lk.wr_data = pwdata_i;
    // power-up restores the remembered schedule index
    if (!nv_loaded_reg && nv_index_i <= SCHED_LAST) begin
      sel_next = nv_index_i;
    end
    if (wr_fire) begin
      case (paddr_i)
        REG_CFG: begin
          unit_next = pwdata_i[CFG_UNIT_LSB +: 2];
          dia_next = pwdata_i[CFG_DIA_LSB +: VAL_W];
        end
        REG_SEL: begin
          if (pwdata_i[IDX_W-1:0] <= SCHED_LAST) begin
            sel_next = pwdata_i[IDX_W-1:0];
            nv_store_next = 1'b1;
          end
        end
        REG_EDIT: begin
          if (pwdata_i[IDX_W-1:0] <= SCHED_LAST) begin
            edit_next = pwdata_i[IDX_W-1:0];
          end
        end
        REG_SEQ: begin
          lk.wr_en = 1'b1;
          lk.wr_word = WORD_SEQ;
        end
        REG_LIM: begin
          lk.wr_en = 1'b1;
          lk.wr_word = WORD_LIM;
        end
        REG_TRIG: begin
          lk.wr_en = 1'b1;
          lk.wr_word = WORD_TRIG;
        end
        REG_CTRL: begin
          start_cmd = start_cmd | pwdata_i[CTRL_START];
          abort_cmd = pwdata_i[CTRL_ABORT];
        end
        REG_IRQ_EN: irq_en_next = pwdata_i[STATUS_W-1:0];
        REG_IRQ_CLR: clr_mask = pwdata_i[STATUS_W-1:0];
        default: ;
      endcase
    end
    // a new event beats a clear in the same cycle
    status_next = (status_reg & ~clr_mask) | ev;
    irq_next = |(status_reg & irq_en_reg);
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      unit_reg <= UNIT_PSI;
      dia_reg <= '0;
      sel_reg <= '0;
      edit_reg <= '0;
      status_reg <= '0;
      irq_en_reg <= '0;
      irq_reg <= 1'b0;
      nv_loaded_reg <= 1'b0;
      nv_store_reg <= 1'b0;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      unit_reg <= unit_next;
      dia_reg <= dia_next;
      sel_reg <= sel_next;
      edit_reg <= edit_next;
      status_reg <= status_next;
      irq_en_reg <= irq_en_next;
      irq_reg <= irq_next;
      nv_loaded_reg <= nv_loaded_next;
      nv_store_reg <= nv_store_next;
    end
  end

  // running schedule fields and feeds to the converter
  always_comb begin
    sq_len = lk.run_q[WORD_SEQ][SQZ_LSB +: IDX_W];
    if (sq_len > SQZ_MAX) begin
      sq_len = SQZ_MAX;
    end
    mon_en = lk.run_q[WORD_SEQ][MON_BIT];
    pre_en = lk.run_q[WORD_SEQ][PRE_BIT];
    sense = spm_sense_e'(lk.run_q[WORD_SEQ][SENSE_LSB +: 2]);
    chain_en = lk.run_q[WORD_SEQ][CHAIN_BIT];
    nxt_idx = lk.run_q[WORD_SEQ][NEXT_LSB +: IDX_W];
    trig = lk.run_q[WORD_TRIG][TRIG_LSB +: VAL_W];
    lk.pct = lk.run_q[WORD_TRIG][PCT_LSB +: PCT_W];
    if (lk.pct > PCT_MAX) begin
      lk.pct = PCT_MAX;
    end
    lk.hi = lk.run_q[WORD_LIM][HI_LSB +: VAL_W];
    lk.lo = lk.run_q[WORD_LIM][LO_LSB +: VAL_W];
    lk.unit = unit_reg;
    lk.dia = dia_reg;
    lk.code = sensor_code_i;
    lk.run_addr = run_reg;
    lk.ed_addr = edit_reg;
    trig_met = (sense == SENSE_FALL) ? (lk.meas <= trig)
      : (lk.meas >= trig);
  end

  // squeeze sequencer
  always_comb begin
    state_next = state_reg;
    run_next = run_reg;
    cnt_next = cnt_reg;
    wait_next = wait_reg;
    done_next = 1'b0;
    ev = '0;
    unique case (state_reg)
      ST_IDLE, ST_OFF: begin
        if (start_cmd) begin
          run_next = sel_reg;
          cnt_next = '0;
          state_next = ST_SQZ;
        end
      end
      ST_SQZ: begin
        if (cnt_reg >= sq_len) begin
          state_next = ST_EVAL;
        end else if (line_tick_i) begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_EVAL: begin
        // one evaluation per squeeze, on its end
        ev[ST_HIGH_FORCE] = mon_en & (lk.meas >= lk.hi);
        ev[ST_LOW_FORCE] = mon_en & (lk.meas <= lk.lo);
        ev[ST_HIGH_PRE] = mon_en & pre_en & (lk.meas >= lk.pre_hi);
        ev[ST_LOW_PRE] = mon_en & pre_en & (lk.meas <= lk.pre_lo);
        wait_next = '0;
        if (sense == SENSE_OFF || sense == SENSE_RSVD || trig_met) begin
          state_next = ST_DONE;
        end else begin
          ev[ST_NOT_READY] = 1'b1;
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (trig_met) begin
          state_next = ST_DONE;
        end else if (wait_reg >= TIMEOUT_CYCLES) begin
          ev[ST_VALVE_TMO] = 1'b1;
          state_next = ST_OFF;
        end else begin
          wait_next = wait_reg + 1'b1;
        end
      end
      ST_DONE: begin
        done_next = 1'b1;
        ev[ST_STEP_DONE] = 1'b1;
        if (chain_en && nxt_idx <= SCHED_LAST) begin
          run_next = nxt_idx;
          cnt_next = '0;
          state_next = ST_SQZ;
        end else begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (abort_cmd) begin
      state_next = ST_IDLE;
    end
    valve_next = (state_reg == ST_SQZ || state_reg == ST_EVAL
      || state_reg == ST_WAIT) ? lk.run_q[WORD_SEQ][VALVE_LSB +: VALVE_N]
      : '0;
    sqz_next = (state_reg == ST_SQZ);
    nrdy_next = (state_reg == ST_WAIT);
    off_next = (state_reg == ST_OFF);
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      run_reg <= '0;
      cnt_reg <= '0;
      wait_reg <= '0;
      valve_reg <= '0;
      sqz_reg <= 1'b0;
      nrdy_reg <= 1'b0;
      done_reg <= 1'b0;
      off_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      run_reg <= run_next;
      cnt_reg <= cnt_next;
      wait_reg <= wait_next;
      valve_reg <= valve_next;
      sqz_reg <= sqz_next;
      nrdy_reg <= nrdy_next;
      done_reg <= done_next;
      off_reg <= off_next;
    end
  end

  // outputs straight from flops
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign valve_o = valve_reg;
  assign squeezing_o = sqz_reg;
  assign valve_not_ready_flag_o = nrdy_reg;
  assign step_done_o = done_reg;
  assign seq_off_o = off_reg;
  assign irq_o = irq_reg;
  assign nv_store_o = nv_store_reg;
  assign nv_index_o = sel_reg;
endmodule // spm_top

// ===== src/spm_pkg.sv
package spm_pkg;

  // clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SENSE_TIMEOUT_S = 60;
  localparam int TMO_W = 33;
  localparam logic [TMO_W-1:0] SENSE_TIMEOUT_CYC =
    TMO_W'(64'(SENSE_TIMEOUT_S) * 64'(CLK_HZ));

  // widths and sizes
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 7;
  localparam int VALVE_N = 8;
  localparam int WORDS = 3;
  localparam int VAL_W = 16;
  localparam int PCT_W = 7;
  localparam int STATUS_W = 7;
  localparam int NUM_SCHED = 100;
  localparam logic [IDX_W-1:0] SCHED_LAST = 7'h63;
  localparam logic [IDX_W-1:0] SQZ_MAX = 7'h63;
  localparam logic [PCT_W-1:0] PCT_MAX = 7'h63;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SEL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_EDIT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SEQ = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_LIM = 8'h10;
  localparam logic [ADDR_W-1:0] REG_TRIG = 8'h14;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h20;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h24;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h28;
  localparam logic [ADDR_W-1:0] REG_MEAS = 8'h2C;

  // schedule word indexes
  localparam logic [1:0] WORD_SEQ = 2'h0;
  localparam logic [1:0] WORD_LIM = 2'h1;
  localparam logic [1:0] WORD_TRIG = 2'h2;

  // field positions
  localparam int CFG_UNIT_LSB = 0;
  localparam int CFG_DIA_LSB = 16;
  localparam int SQZ_LSB = 0;
  localparam int VALVE_LSB = 8;
  localparam int MON_BIT = 16;
  localparam int PRE_BIT = 17;
  localparam int SENSE_LSB = 18;
  localparam int CHAIN_BIT = 20;
  localparam int NEXT_LSB = 21;
  localparam int HI_LSB = 0;
  localparam int LO_LSB = 16;
  localparam int TRIG_LSB = 0;
  localparam int PCT_LSB = 16;
  localparam int CTRL_START = 0;
  localparam int CTRL_ABORT = 1;
  localparam int STV_STATE_LSB = 0;
  localparam int STV_RUN_LSB = 8;
  localparam int STV_CNT_LSB = 16;

  // status bits
  localparam int ST_HIGH_FORCE = 0;
  localparam int ST_LOW_FORCE = 1;
  localparam int ST_HIGH_PRE = 2;
  localparam int ST_LOW_PRE = 3;
  localparam int ST_VALVE_TMO = 4;
  localparam int ST_NOT_READY = 5;
  localparam int ST_STEP_DONE = 6;

  // measurement units: pressure, force, loop current
  localparam logic [1:0] UNIT_PSI = 2'h0;
  localparam logic [1:0] UNIT_LB = 2'h1;
  localparam logic [1:0] UNIT_MA = 2'h2;

  // conversion: mA in 0.01 mA, PSI in 0.01 PSI, force in 0.5 lb
  localparam logic [VAL_W-1:0] MA_ZERO = 16'h0190;
  localparam logic [20:0] PSI_NUM = 21'h000019;
  localparam int PSI_SHIFT = 2;
  localparam logic [63:0] PI_NUM = 64'h0000_0000_0000_0C91;
  localparam logic [63:0] FORCE_DEN = 64'h0000_0000_7A12_0000;
  localparam logic [VAL_W-1:0] VAL_MAX = 16'hFFFF;
  localparam logic [7:0] PCT_FULL = 8'h64;

  typedef enum logic [1:0] {
    SENSE_OFF = 2'h0,
    SENSE_RISE = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RSVD = 2'h3
  } spm_sense_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SQZ = 3'h1,
    ST_EVAL = 3'h3,
    ST_WAIT = 3'h2,
    ST_DONE = 3'h6,
    ST_OFF = 3'h4
  } spm_state_e;

endpackage

// ===== src/spm_link_if.sv
`timescale 1ns/1ns
// schedule store and measurement path between sequencer and helpers
interface spm_link_if import spm_pkg::*; ();
  logic wr_en;
  logic [1:0] wr_word;
  logic [IDX_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [IDX_W-1:0] ed_addr;
  logic [IDX_W-1:0] run_addr;
  logic [WORDS-1:0][DATA_W-1:0] ed_q;
  logic [WORDS-1:0][DATA_W-1:0] run_q;
  logic [1:0] unit;
  logic [VAL_W-1:0] dia;
  logic [VAL_W-1:0] code;
  logic [VAL_W-1:0] hi;
  logic [VAL_W-1:0] lo;
  logic [PCT_W-1:0] pct;
  logic [VAL_W-1:0] meas;
  logic [VAL_W-1:0] pre_hi;
  logic [VAL_W-1:0] pre_lo;

  modport ctl (output wr_en, wr_word, wr_addr, wr_data, ed_addr, run_addr,
    unit, dia, code, hi, lo, pct, input ed_q, run_q, meas, pre_hi, pre_lo);
  modport mem (input wr_en, wr_word, wr_addr, wr_data, ed_addr, run_addr,
    output ed_q, run_q);
  modport cnv (input unit, dia, code, hi, lo, pct,
    output meas, pre_hi, pre_lo);
endinterface

// ===== src/spm_sched_mem.sv
`timescale 1ns/1ns
module spm_sched_mem import spm_pkg::*; (
  // clock
  input wire logic clock_i,
  // schedule port
  spm_link_if.mem lk
);
  logic [WORDS-1:0][DATA_W-1:0] mem [0:NUM_SCHED-1];

  // word write, indexes past the last schedule are dropped
  always_ff @(posedge clock_i) begin
    if (lk.wr_en && lk.wr_addr <= SCHED_LAST && lk.wr_word <= WORD_TRIG) begin
      mem[lk.wr_addr][lk.wr_word] <= lk.wr_data;
    end
  end

  // edit and run reads
  always_comb begin
    lk.ed_q = (lk.ed_addr <= SCHED_LAST) ? mem[lk.ed_addr] : '0;
    lk.run_q = (lk.run_addr <= SCHED_LAST) ? mem[lk.run_addr] : '0;
  end
endmodule // spm_sched_mem

// ===== src/spm_conv.sv
`timescale 1ns/1ns
module spm_conv import spm_pkg::*; (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // measurement port
  spm_link_if.cnv lk
);
  logic [VAL_W-1:0] meas_reg, meas_next;
  logic [VAL_W-1:0] pre_hi_reg, pre_hi_next;
  logic [VAL_W-1:0] pre_lo_reg, pre_lo_next;
  logic [VAL_W-1:0] ma_off;
  logic [20:0] psi_w;
  logic [63:0] force_w;
  logic [23:0] plo_w;

  // sensor current to selected unit and derived pre-limits
  always_comb begin
    ma_off = (lk.code > MA_ZERO) ? lk.code - MA_ZERO : '0;
    psi_w = (21'(ma_off) * PSI_NUM) >> PSI_SHIFT;
    force_w = 64'(psi_w) * 64'(lk.dia) * 64'(lk.dia) * PI_NUM
      / FORCE_DEN;
    if (lk.unit == UNIT_MA) begin
      meas_next = lk.code;
    end else if (lk.unit == UNIT_PSI) begin
      meas_next = psi_w[VAL_W-1:0];
    end else begin
      meas_next = (force_w > 64'(VAL_MAX)) ? VAL_MAX : force_w[VAL_W-1:0];
    end
    pre_hi_next = 16'((24'(lk.hi) * 24'(PCT_FULL - 8'(lk.pct)))
      / 24'(PCT_FULL));
    plo_w = (24'(lk.lo) * 24'(PCT_FULL + 8'(lk.pct))) / 24'(PCT_FULL);
    pre_lo_next = (plo_w > 24'(VAL_MAX)) ? VAL_MAX : plo_w[VAL_W-1:0];
  end

  // result registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      meas_reg <= '0;
      pre_hi_reg <= '0;
      pre_lo_reg <= '0;
    end else begin
      meas_reg <= meas_next;
      pre_hi_reg <= pre_hi_next;
      pre_lo_reg <= pre_lo_next;
    end
  end

  assign lk.meas = meas_reg;
  assign lk.pre_hi = pre_hi_reg;
  assign lk.pre_lo = pre_lo_reg;
endmodule // spm_conv

// ===== bench/spm_sensor_model.sv
`timescale 1ns/1ns
module spm_sensor_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // wanted loop current and slew per cycle, 0.01 mA
  input wire logic [15:0] target_i,
  input wire logic [15:0] step_i,
  // loop current seen by the device
  output logic [15:0] code_o
);
  logic [15:0] diff;
  // distance still to travel toward the wanted current
  always_comb diff = (code_o > target_i) ? code_o - target_i :
    target_i - code_o;
  // slews toward the target; resets to 4 mA, the zero-pressure level
  always_ff @(posedge clock_i) begin
    if (reset_i)
      code_o <= 16'h0190;
    else if (diff <= step_i)
      code_o <= target_i;
    else if (code_o < target_i)
      code_o <= code_o + step_i;
    else
      code_o <= code_o - step_i;
  end
endmodule // spm_sensor_model

// ===== bench/spm_top_assertions.sv
`timescale 1ns/1ns
module spm_top_assertions import spm_pkg::*; #(
  parameter logic [TMO_W-1:0] TIMEOUT_CYCLES = SENSE_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [DATA_W-1:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // sequence side
  input wire logic [VALVE_N-1:0] valve_o,
  input wire logic squeezing_o,
  input wire logic valve_not_ready_flag_o,
  input wire logic step_done_o,
  input wire logic seq_off_o,
  input wire logic [IDX_W-1:0] nv_index_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // bus answers after exactly one wait state, for one cycle
  ready_wait_a: assert property ($rose(penable_i) && psel_i |=> pready_o)
    else $error("pready not one cycle after access start");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr_o |-> pready_o && prdata_o == '0)
    else $error("pslverr without pready or with data");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == '0)
    else $error("read data outside answer cycle");
  // sequencer outputs
  step_pulse_a: assert property (step_done_o |=> !step_done_o)
    else $error("step done longer than one cycle");
  wait_quiet_a: assert property (
    valve_not_ready_flag_o |-> !squeezing_o && !step_done_o)
    else $error("not ready flag while squeezing or stepping");
  off_from_wait_a: assert property ($rose(seq_off_o) |->
    $past(valve_not_ready_flag_o) && valve_o == '0)
    else $error("off state not entered from a sensing wait");
  index_range_a: assert property (nv_index_o <= SCHED_LAST)
    else $error("schedule index above last");
  // consecutive not-ready cycles, bounded by the sensing timeout
  logic [TMO_W:0] nrdy_cnt;
  always_ff @(posedge clock_i) begin
    if (reset_i || !valve_not_ready_flag_o) begin
      nrdy_cnt <= '0;
    end else begin
      nrdy_cnt <= nrdy_cnt + 1'b1;
    end
  end
  wait_bound_a: assert property (
    nrdy_cnt <= {1'b0, TIMEOUT_CYCLES} + 1'b1)
    else $error("sensing wait outlived its timeout");
  // main scenarios
  step_c: cover property (step_done_o);
  off_c: cover property ($rose(seq_off_o));
  err_c: cover property (pslverr_o);
  wait_c: cover property (valve_not_ready_flag_o);
endmodule // spm_top_assertions

bind spm_top spm_top_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_chk (
  .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .valve_o(valve_o), .squeezing_o(squeezing_o),
  .valve_not_ready_flag_o(valve_not_ready_flag_o),
  .step_done_o(step_done_o), .seq_off_o(seq_off_o),
  .nv_index_o(nv_index_o));

// ===== bench/test_squeeze_pressure_monitor.sv
`timescale 1ns/1ns
module test_squeeze_pressure_monitor import spm_pkg::*;;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [ADDR_W-1:0] paddr_i = '0;
  logic [DATA_W-1:0] pwdata_i = '0;
  logic line_tick_i = 1'b0;
  logic start_i = 1'b0;
  logic [IDX_W-1:0] nv_index_i = 7'h05;
  logic [15:0] target = 16'h04B0;
  logic [15:0] slew = 16'hFFFF;
  logic [VAL_W-1:0] sensor_code;
  logic [DATA_W-1:0] prdata_o;
  logic [DATA_W-1:0] q;
  logic [VALVE_N-1:0] valve_o;
  logic [IDX_W-1:0] nv_index_o;
  logic pready_o, pslverr_o, squeezing_o, flag, step_done_o;
  logic seq_off_o, irq_o, nv_store_o, err;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int stores = 0;
  int n;
  // clock and run limit
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    stores += (nv_store_o === 1'b1);
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  // sensor and device
  spm_sensor_model i_sensor (.clock_i(clock_i), .reset_i(reset_i),
    .target_i(target), .step_i(slew), .code_o(sensor_code));
  spm_top #(.TIMEOUT_CYCLES(TMO_W'(50))) i_dut (.clock_i(clock_i),
    .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .line_tick_i(line_tick_i), .start_i(start_i),
    .sensor_code_i(sensor_code), .nv_index_i(nv_index_i),
    .valve_o(valve_o), .squeezing_o(squeezing_o),
    .valve_not_ready_flag_o(flag), .step_done_o(step_done_o),
    .seq_off_o(seq_off_o), .irq_o(irq_o), .nv_store_o(nv_store_o),
    .nv_index_o(nv_index_o));
  // compare and report
  task automatic check(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    q = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    check(32'(pready_o), 32'h1, "apb answer");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string m);
    apb(1'b0, a, '0);
    check(q, e, m);
  endtask
  // line ticks spaced three cycles apart
  task automatic ticks(input int t);
    repeat (t) begin
      repeat (2) @(posedge clock_i);
      line_tick_i <= 1'b1;
      @(posedge clock_i);
      line_tick_i <= 1'b0;
    end
  endtask
  task automatic wait_end;
    n = 0;
    while (step_done_o !== 1'b1 && seq_off_o !== 1'b1 && n < 200) begin
      @(posedge clock_i);
      n++;
    end
  endtask
  task automatic run(input logic [31:0] sq, lim, trig);
    apb(1'b1, REG_IRQ_CLR, 32'h7F);
    apb(1'b1, REG_SEQ, sq);
    apb(1'b1, REG_LIM, lim);
    apb(1'b1, REG_TRIG, trig);
    apb(1'b1, REG_CTRL, 32'h1);
  endtask
  // index restore, selection, unmapped access, units
  task automatic t_regs;
    check(nv_index_o, 7'h05, "restored index");
    rd(8'h3C, '0, "unmapped data");
    check(err, 1'b1, "unmapped error");
    apb(1'b1, REG_SEL, 32'h64);
    apb(1'b1, REG_SEL, 32'h2A);
    repeat (2) @(posedge clock_i);
    check(nv_index_o, 7'h2A, "selected index");
    check(stores, 1, "store pulses");
    apb(1'b1, REG_EDIT, 32'h2A);
    apb(1'b1, REG_CFG, 32'h2);
    rd(REG_MEAS, 32'h04B0, "ma reading");
    apb(1'b1, REG_CFG, 32'h00C8_0001);
    rd(REG_MEAS, 32'h013A, "force reading");
    apb(1'b1, REG_CFG, 32'h0);
    rd(REG_MEAS, 32'h1388, "psi reading");
  endtask
  // squeeze length, valves, sensing off, interrupt
  task automatic t_squeeze;
    run(32'h0000_A503, '0, '0);
    repeat (3) @(posedge clock_i);
    check(valve_o, 8'hA5, "valves on");
    ticks(2);
    check({squeezing_o, step_done_o}, 2'b10, "still squeezing");
    ticks(1);
    wait_end();
    check(n < 8, 1'b1, "squeeze end");
    rd(REG_STATUS, 32'h40, "status plain");
    apb(1'b1, REG_IRQ_EN, 32'h40);
    repeat (2) @(posedge clock_i);
    check(irq_o, 1'b1, "irq raised");
    apb(1'b1, REG_IRQ_CLR, 32'h40);
    repeat (2) @(posedge clock_i);
    check(irq_o, 1'b0, "irq cleared");
    apb(1'b1, REG_IRQ_EN, 32'h0);
    run('0, '0, '0);
    wait_end();
    check(n < 6, 1'b1, "zero squeeze");
  endtask
  // limit and pre-limit table at 50.00 PSI
  task automatic t_limits;
    logic [31:0] sq [6] = '{32'h30000, 32'h30000, 32'h30000, 32'h10000, 0,
      32'h30000};
    logic [31:0] lm [6] = '{32'h0FA0_1388, 32'h1388_1770, 32'h1194_157C,
      32'h1194_157C, 32'h1388_1388, 32'h09C4_157C};
    logic [31:0] tg [6] = '{0, 0, 32'hA0000, 32'hA0000, 0, 32'h7F0000};
    logic [31:0] ex [6] = '{32'h45, 32'h4A, 32'h44, 32'h40, 32'h40, 32'h44};
    for (int i = 0; i < 6; i++) begin
      run(sq[i], lm[i], tg[i]);
      wait_end();
      repeat (4) @(posedge clock_i);
      rd(REG_STATUS, ex[i], "limit status");
    end
  endtask
  // rising wait released by a slow sensor, falling wait timing out
  task automatic t_sense;
    run(32'h0005_8100, 32'h0000_FFFF, 32'h1770);
    repeat (10) @(posedge clock_i);
    check({flag, valve_o}, 9'h181, "rise waiting");
    slew <= 16'h0014;
    target <= 16'h0640;
    wait_end();
    check(step_done_o, 1'b1, "rise advance");
    rd(REG_STATUS, 32'h60, "rise status");
    run(32'h0009_0000, 32'h0000_FFFF, 32'h1770);
    repeat (10) @(posedge clock_i);
    check(flag, 1'b1, "fall waiting");
    wait_end();
    check(seq_off_o, 1'b1, "timeout off");
    rd(REG_STATUS, 32'h30, "timeout status");
    apb(1'b1, REG_CTRL, 32'h2);
    repeat (2) @(posedge clock_i);
    check(seq_off_o, 1'b0, "abort to idle");
  endtask
  // two chained schedules started from the pin
  task automatic t_chain;
    apb(1'b1, REG_EDIT, 32'h2B);
    apb(1'b1, REG_SEQ, '0);
    apb(1'b1, REG_EDIT, 32'h2A);
    apb(1'b1, REG_IRQ_CLR, 32'h7F);
    apb(1'b1, REG_SEQ, 32'h0570_0000);
    start_i <= 1'b1;
    repeat (16) @(posedge clock_i);
    start_i <= 1'b0;
    rd(REG_STATE, 32'h2B00, "chain state");
    rd(REG_STATUS, 32'h40, "chain status");
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    t_regs();
    t_squeeze();
    t_limits();
    t_sense();
    t_chain();
    summarize();
  end
endmodule // test_squeeze_pressure_monitor
